// *** hdl/sdtc_pkg.sv ***
// Purpose: shared constants for the synchronous termination link
// Assumes: both ends run on ref_clk_in at 100 MHz
// Notes:   latencies count link clock cycles, not ref clock cycles
package sdtc_pkg;
  // widths
  localparam int LAT_W  = 5;
  localparam int PIPE_D = 32;
  localparam int HOLD_W = 3;
  localparam int DIV_W  = 4;
  // link pin positions in the sampled pin vector
  localparam int PIN_CLK = 0;
  localparam int PIN_CKE = 1;
  localparam int PIN_ODT = 2;
  localparam int PIN_WR  = 3;
  localparam int PIN_BC4 = 4;
  localparam int PIN_N   = 5;
  // additive latency field codes (mode register 1 bits 4 and 3)
  localparam logic [1:0] AL_FIELD_ZERO = 2'h0;
  localparam logic [1:0] AL_FIELD_CL1  = 2'h1;
  localparam logic [1:0] AL_FIELD_CL2  = 2'h2;
  // latency arithmetic
  localparam logic [LAT_W-1:0] LAT_OFFSET = 5'h02;
  localparam logic [3:0]       AL_CL1_SUB = 4'h1;
  localparam logic [3:0]       AL_CL2_SUB = 4'h2;
  // minimum high times of the termination pin, in link cycles
  localparam logic [HOLD_W-1:0] SHORT_BURST_HOLD = 3'h4;
  localparam logic [HOLD_W-1:0] LONG_BURST_HOLD  = 3'h6;
  // link clock divider: half period in ref cycles, minus one
  localparam logic [DIV_W-1:0] DIV_LAST = 4'h7;
  // values after reset
  localparam logic [LAT_W-1:0]  RST_LAT  = 5'h00;
  localparam logic [PIPE_D-1:0] RST_PIPE = 32'h0000_0000;
  localparam logic [HOLD_W-1:0] RST_HOLD = 3'h0;
  localparam logic [DIV_W-1:0]  RST_DIV  = 4'h0;
  localparam logic [PIN_N-1:0]  RST_PINS = 5'h00;
endpackage : sdtc_pkg

// *** hdl/sdtc_link_if.sv ***
// Purpose: pins between memory controller and termination logic
// Assumes: controller drives every pin, memory only listens
// Notes:   no clocking block; the memory end samples the link clock
`timescale 1ns/1ps
`default_nettype none
interface sdtc_link_if;
  logic dram_clk;
  logic cke;
  logic odt;
  logic wr_cmd;
  logic bc4;
  // controller end
  modport ctrl (output dram_clk, output cke, output odt,
                output wr_cmd, output bc4);
  // memory end
  modport dram (input dram_clk, input cke, input odt,
                input wr_cmd, input bc4);
endinterface : sdtc_link_if
`default_nettype wire

// *** hdl/sdtc_dram_end.sv ***
// Purpose: synchronous termination control of the memory end
// Assumes: mode fields are static between mode_load_in pulses
// Notes:   link pins are sampled by ref_clk_in; asynchronous mode,
//          power-down transitions and analog skew are not modelled
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - sync timing needs locked DLL, termination enabled
// - valid states: CKE high, power-down per DLL bit
// - termination on turn-on latency after high sample
// - termination off turn-off latency after low sample
// - both latencies equal write latency minus two
// - write latency is CWL plus additive latency
// - controller holds pin high four cycles minimum
// - after write hold four (chop) or six cycles
// - holds count from high or write to low edge
// - controller honours the longer of both holds
// - write-only termination may keep pin high
// - dynamic switching when write termination field nonzero
// - switch to write value latency after write
// - revert after off latency plus four or six
module sdtc_dram_end (
  // clock and reset
  input  wire logic                     ref_clk_in,
  input  wire logic                     rst_in,
  // link from the controller
  sdtc_link_if.dram                     link,
  // mode register fields
  input  wire logic                     mode_load_in,
  input  wire logic [3:0]               cas_latency_in,
  input  wire logic [3:0]               cas_write_latency_in,
  input  wire logic [1:0]               additive_field_in,
  input  wire logic [2:0]               nominal_termination_in,
  input  wire logic [1:0]               write_termination_in,
  input  wire logic                     dll_pd_keep_in,
  // device state
  input  wire logic                     dll_on_in,
  input  wire logic                     dll_locked_in,
  input  wire logic                     banks_open_in,
  // termination control
  output logic                          sync_mode_out,
  output logic                          term_on_out,
  output logic                          term_write_sel_out,
  output logic [sdtc_pkg::LAT_W-1:0]    term_latency_out
);

  logic [sdtc_pkg::PIN_N-1:0]   pin_raw;
  logic [sdtc_pkg::PIN_N-1:0]   s1_r;
  logic [sdtc_pkg::PIN_N-1:0]   s2_r;
  logic [sdtc_pkg::PIN_N-1:0]   s3_r;
  logic [sdtc_pkg::PIN_N-1:0]   lvl_r;
  logic [sdtc_pkg::PIN_N-1:0]   lvl_nxt;
  logic                         clk_prev_r;
  logic                         rise;
  logic [sdtc_pkg::LAT_W-1:0]   lat_r;
  logic [sdtc_pkg::LAT_W-1:0]   lat_nxt;
  logic [3:0]                   al_val;
  logic [sdtc_pkg::LAT_W-1:0]   wl_val;
  logic [sdtc_pkg::PIPE_D-1:0]  odt_pipe_r;
  logic [sdtc_pkg::PIPE_D-1:0]  odt_pipe_nxt;
  logic [sdtc_pkg::PIPE_D-1:0]  wr_pipe_r;
  logic [sdtc_pkg::PIPE_D-1:0]  wr_pipe_nxt;
  logic [sdtc_pkg::PIPE_D-1:0]  bc4_pipe_r;
  logic [sdtc_pkg::PIPE_D-1:0]  bc4_pipe_nxt;
  logic                         sync_r;
  logic                         sync_nxt;
  logic                         term_r;
  logic                         term_nxt;
  logic                         sel_r;
  logic                         sel_nxt;
  logic [sdtc_pkg::HOLD_W-1:0]  win_r;
  logic [sdtc_pkg::HOLD_W-1:0]  win_nxt;
  logic                         dyn_en;
  logic                         term_en;

  // gather the link pins in one vector for the synchroniser
  assign pin_raw[sdtc_pkg::PIN_CLK] = link.dram_clk;
  assign pin_raw[sdtc_pkg::PIN_CKE] = link.cke;
  assign pin_raw[sdtc_pkg::PIN_ODT] = link.odt;
  assign pin_raw[sdtc_pkg::PIN_WR]  = link.wr_cmd;
  assign pin_raw[sdtc_pkg::PIN_BC4] = link.bc4;

  // a pin level counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < sdtc_pkg::PIN_N; gi++) begin : g_filt
      assign lvl_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : lvl_r[gi];
    end
  endgenerate

  // three-stage synchroniser; stage one feeds stage two only
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_r       <= sdtc_pkg::RST_PINS;
      s2_r       <= sdtc_pkg::RST_PINS;
      s3_r       <= sdtc_pkg::RST_PINS;
      lvl_r      <= sdtc_pkg::RST_PINS;
      clk_prev_r <= 1'b0;
    end else begin
      s1_r       <= pin_raw;
      s2_r       <= s1_r;
      s3_r       <= s2_r;
      lvl_r      <= lvl_nxt;
      clk_prev_r <= lvl_r[sdtc_pkg::PIN_CLK];
    end
  end

  // rising link edge; data levels sampled here are pre-edge values
  assign rise = lvl_r[sdtc_pkg::PIN_CLK] & ~clk_prev_r;

  // termination is enabled if either value field is nonzero
  assign term_en = (nominal_termination_in != 3'h0) |
                   (write_termination_in != 2'h0);
  assign dyn_en  = (write_termination_in != 2'h0);

  // latency from mode fields, only taken on a mode load
  always_comb begin
    unique case (additive_field_in)
      sdtc_pkg::AL_FIELD_ZERO: al_val = 4'h0;
      sdtc_pkg::AL_FIELD_CL1:  al_val = cas_latency_in - sdtc_pkg::AL_CL1_SUB;
      sdtc_pkg::AL_FIELD_CL2:  al_val = cas_latency_in - sdtc_pkg::AL_CL2_SUB;
      default:                 al_val = 4'h0;   // reserved code
    endcase
    wl_val  = {1'b0, cas_write_latency_in} + {1'b0, al_val};
    lat_nxt = lat_r;
    if (mode_load_in) begin
      // clamp keeps a bad setting from wrapping the pipeline index
      if (wl_val >= sdtc_pkg::LAT_OFFSET) begin
        lat_nxt = wl_val - sdtc_pkg::LAT_OFFSET;
      end else begin
        lat_nxt = sdtc_pkg::RST_LAT;
      end
    end
  end

  // operating state decides whether synchronous timing applies
  always_comb begin
    sync_nxt = dll_on_in & dll_locked_in & term_en &
               (lvl_r[sdtc_pkg::PIN_CKE] | banks_open_in |
                dll_pd_keep_in);
  end

  // termination pin pipeline, one stage per rising link edge
  always_comb begin
    odt_pipe_nxt = odt_pipe_r;
    wr_pipe_nxt  = wr_pipe_r;
    bc4_pipe_nxt = bc4_pipe_r;
    term_nxt     = term_r;
    if (rise) begin
      odt_pipe_nxt = {odt_pipe_r[sdtc_pkg::PIPE_D-2:0],
                      lvl_r[sdtc_pkg::PIN_ODT]};
      // a write is only registered while CKE is high
      wr_pipe_nxt  = {wr_pipe_r[sdtc_pkg::PIPE_D-2:0],
                      lvl_r[sdtc_pkg::PIN_WR] &
                      lvl_r[sdtc_pkg::PIN_CKE]};
      bc4_pipe_nxt = {bc4_pipe_r[sdtc_pkg::PIPE_D-2:0],
                      lvl_r[sdtc_pkg::PIN_BC4]};
      // same depth serves turn-on and turn-off alike
      term_nxt     = sync_r & odt_pipe_nxt[lat_r];
    end
    if (!sync_r) begin
      term_nxt = 1'b0;
    end
  end

  // write window: switch value latency after write, hold 4 or 6
  always_comb begin
    sel_nxt = sel_r;
    win_nxt = win_r;
    if (rise) begin
      if (dyn_en && wr_pipe_nxt[lat_r]) begin
        // a new write reloads the window; the set wins
        sel_nxt = 1'b1;
        win_nxt = bc4_pipe_nxt[lat_r] ?
                  sdtc_pkg::SHORT_BURST_HOLD - 3'h1 :
                  sdtc_pkg::LONG_BURST_HOLD - 3'h1;
      end else if (sel_r) begin
        if (win_r == sdtc_pkg::RST_HOLD) begin
          sel_nxt = 1'b0;
        end else begin
          win_nxt = win_r - 3'h1;
        end
      end
    end
    if (!sync_r || !dyn_en) begin
      sel_nxt = 1'b0;
      win_nxt = sdtc_pkg::RST_HOLD;
    end
  end

  // state registers of latency, pipelines and termination outputs
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lat_r      <= sdtc_pkg::RST_LAT;
      sync_r     <= 1'b0;
      odt_pipe_r <= sdtc_pkg::RST_PIPE;
      wr_pipe_r  <= sdtc_pkg::RST_PIPE;
      bc4_pipe_r <= sdtc_pkg::RST_PIPE;
      term_r     <= 1'b0;
      sel_r      <= 1'b0;
      win_r      <= sdtc_pkg::RST_HOLD;
    end else begin
      lat_r      <= lat_nxt;
      sync_r     <= sync_nxt;
      odt_pipe_r <= odt_pipe_nxt;
      wr_pipe_r  <= wr_pipe_nxt;
      bc4_pipe_r <= bc4_pipe_nxt;
      term_r     <= term_nxt;
      sel_r      <= sel_nxt;
      win_r      <= win_nxt;
    end
  end

  // outputs straight from flops
  assign sync_mode_out      = sync_r;
  assign term_on_out        = term_r;
  assign term_write_sel_out = sel_r;
  assign term_latency_out   = lat_r;

endmodule : sdtc_dram_end
`default_nettype wire

// *** hdl/sdtc_ctrl_end.sv ***
// Purpose: controller end that drives link clock, CKE, pin and writes
// Assumes: user side is synchronous to ref_clk_in
// Notes:   pins change at the falling link edge, half a cycle ahead
`timescale 1ns/1ps
`default_nettype none
module sdtc_ctrl_end (
  // clock and reset
  input  wire logic  ref_clk_in,
  input  wire logic  rst_in,
  // link to the memory
  sdtc_link_if.ctrl  link,
  // user requests
  input  wire logic  term_req_in,
  input  wire logic  nominal_off_in,
  input  wire logic  cke_in,
  input  wire logic  wr_req_in,
  input  wire logic  wr_bc4_in,
  // user status
  output logic       wr_ready_out,
  output logic       term_hold_out
);

  logic [sdtc_pkg::DIV_W-1:0]   div_r;
  logic [sdtc_pkg::DIV_W-1:0]   div_nxt;
  logic                         clk_r;
  logic                         clk_nxt;
  logic                         rise;
  logic                         fall;
  logic                         cke_r;
  logic                         cke_nxt;
  logic                         odt_r;
  logic                         odt_nxt;
  logic                         wr_r;
  logic                         wr_nxt;
  logic                         bc4_r;
  logic                         bc4_nxt;
  logic                         pend_r;
  logic                         pend_nxt;
  logic                         pend_bc4_r;
  logic                         pend_bc4_nxt;
  logic                         seen_r;
  logic                         seen_nxt;
  logic [sdtc_pkg::HOLD_W-1:0]  rem_r;
  logic [sdtc_pkg::HOLD_W-1:0]  rem_nxt;
  logic [sdtc_pkg::HOLD_W-1:0]  need;
  logic                         hold_r;
  logic                         ready_r;

  // divider makes the link clock from the ref clock
  always_comb begin
    div_nxt = div_r + 4'h1;
    clk_nxt = clk_r;
    if (div_r == sdtc_pkg::DIV_LAST) begin
      div_nxt = sdtc_pkg::RST_DIV;
      clk_nxt = ~clk_r;
    end
  end
  assign rise = (div_r == sdtc_pkg::DIV_LAST) & ~clk_r;
  assign fall = (div_r == sdtc_pkg::DIV_LAST) & clk_r;

  // remaining hold, updated at the edges where the memory registers
  always_comb begin
    seen_nxt = seen_r;
    rem_nxt  = rem_r;
    need     = sdtc_pkg::RST_HOLD;
    if (rise) begin
      if (rem_r != sdtc_pkg::RST_HOLD) begin
        rem_nxt = rem_r - 3'h1;
      end
      if (odt_r && !seen_r) begin
        need = sdtc_pkg::SHORT_BURST_HOLD - 3'h1;
      end
      if (odt_r && wr_r) begin
        need = bc4_r ? sdtc_pkg::SHORT_BURST_HOLD - 3'h1 :
                       sdtc_pkg::LONG_BURST_HOLD - 3'h1;
      end
      // keep the longer of the running and the new hold
      if (need > rem_nxt) begin
        rem_nxt = need;
      end
      seen_nxt = odt_r;
    end
  end

  // pins change only at the falling edge so they are stable at rise
  always_comb begin
    cke_nxt      = cke_r;
    odt_nxt      = odt_r;
    wr_nxt       = wr_r;
    bc4_nxt      = bc4_r;
    pend_nxt     = pend_r;
    pend_bc4_nxt = pend_bc4_r;
    if (wr_req_in && !pend_r) begin
      pend_nxt     = 1'b1;
      pend_bc4_nxt = wr_bc4_in;
    end
    if (fall) begin
      cke_nxt = cke_in;
      wr_nxt  = 1'b0;
      // clock enable must be high at the edge that registers the write,
      // or the memory drops the command while the hold still runs
      if (pend_r && cke_nxt) begin
        // a write always goes out with the pin high
        wr_nxt   = 1'b1;
        bc4_nxt  = pend_bc4_r;
        pend_nxt = 1'b0;
      end
      if (term_req_in || nominal_off_in || wr_nxt) begin
        odt_nxt = 1'b1;
      end else if (rem_r == sdtc_pkg::RST_HOLD && !wr_r) begin
        odt_nxt = 1'b0;
      end
    end
  end

  // registers; every link pin comes from one of these
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_r      <= sdtc_pkg::RST_DIV;
      clk_r      <= 1'b0;
      cke_r      <= 1'b0;
      odt_r      <= 1'b0;
      wr_r       <= 1'b0;
      bc4_r      <= 1'b0;
      pend_r     <= 1'b0;
      pend_bc4_r <= 1'b0;
      seen_r     <= 1'b0;
      rem_r      <= sdtc_pkg::RST_HOLD;
      hold_r     <= 1'b0;
      ready_r    <= 1'b1;
    end else begin
      div_r      <= div_nxt;
      clk_r      <= clk_nxt;
      cke_r      <= cke_nxt;
      odt_r      <= odt_nxt;
      wr_r       <= wr_nxt;
      bc4_r      <= bc4_nxt;
      pend_r     <= pend_nxt;
      pend_bc4_r <= pend_bc4_nxt;
      seen_r     <= seen_nxt;
      rem_r      <= rem_nxt;
      hold_r     <= (rem_nxt != sdtc_pkg::RST_HOLD);
      ready_r    <= ~pend_nxt;
    end
  end

  assign link.dram_clk = clk_r;
  assign link.cke      = cke_r;
  assign link.odt      = odt_r;
  assign link.wr_cmd   = wr_r;
  assign link.bc4      = bc4_r;
  assign wr_ready_out  = ready_r;
  assign term_hold_out = hold_r;

endmodule : sdtc_ctrl_end
`default_nettype wire

// *** tb/sdtc_sva.sv ***
// Purpose: wire-level checks on the termination link
// Assumes: link pins come from flops in the ref clock domain
// Notes:   holds are counted in link rises, as the memory registers them
`timescale 1ns/1ps
`default_nettype none
module sdtc_sva (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // link pins
  input wire logic dram_clk,
  input wire logic cke,
  input wire logic odt,
  input wire logic wr_cmd,
  input wire logic bc4
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic       clk_q_r;
  logic       rise;
  logic [3:0] hi_r, hi_nxt;
  logic [2:0] wc_r, wc_nxt, nd_r, nd_nxt;
  // edges since the pin went high and since the last write, saturating
  // so a pin held high for ages never wraps back to a short count
  assign rise = dram_clk & ~clk_q_r;
  always_comb begin
    hi_nxt = hi_r;
    wc_nxt = wc_r;
    nd_nxt = nd_r;
    if (rise) begin
      if (!odt)
        hi_nxt = 4'h0;
      else if (hi_r != 4'hF)
        hi_nxt = hi_r + 4'h1;
      if (wr_cmd) begin
        wc_nxt = 3'h1;
        nd_nxt = bc4 ? 3'h4 : 3'h6;
      end else if (!odt)
        wc_nxt = 3'h0;
      else if (wc_r != 3'h0 && wc_r != 3'h7)
        wc_nxt = wc_r + 3'h1;
    end
  end
  // register the bookkeeping
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_q_r <= 1'b0;
      hi_r    <= 4'h0;
      wc_r    <= 3'h0;
      nd_r    <= 3'h0;
    end else begin
      clk_q_r <= dram_clk;
      hi_r    <= hi_nxt;
      wc_r    <= wc_nxt;
      nd_r    <= nd_nxt;
    end
  end
  chk_short_hold: assert property (
    rise && !odt && hi_r != 4'h0 |-> hi_r >= 4'h4)
    else $error("pin released before the short hold");
  chk_write_hold: assert property (
    rise && !odt && wc_r != 3'h0 |-> wc_r >= nd_r)
    else $error("pin released before the write hold");
  chk_write_odt: assert property (wr_cmd |-> odt)
    else $error("write sent with the pin low");
  chk_write_cke: assert property (wr_cmd |-> cke)
    else $error("write sent with clock enable low");
  chk_write_len: assert property (
    $rose(wr_cmd) |-> wr_cmd [*8] ##1 wr_cmd [*8])
    else $error("write shorter than one link cycle");
  chk_pin_settled: assert property (
    $rose(dram_clk) |-> odt == $past(odt, 4))
    else $error("pin moved too close to a link rise");
  chk_pin_at_fall: assert property ($changed(odt) |-> !dram_clk)
    else $error("pin changed while the link clock was high");
  chk_clk_high: assert property (
    $rose(dram_clk) |-> dram_clk [*8] ##1 !dram_clk)
    else $error("link clock high phase wrong");
  chk_clk_low: assert property (
    $fell(dram_clk) |-> !dram_clk [*8] ##1 dram_clk)
    else $error("link clock low phase wrong");
endmodule : sdtc_sva
`default_nettype wire

// *** tb/tb_sync_dynamic_termination_ctrl.sv ***
// Purpose: drives both ends of the termination link and checks timing
// Assumes: CL 6 and CWL 5, so the base latency is 3 link cycles
// Notes:   the bench numbers link rises itself to time every event
`timescale 1ns/1ps
`default_nettype none
module tb_sync_dynamic_termination_ctrl;
  logic       ref_clk_in, rst_in, term_req, nom_off, cke, wr_req, wr_bc4;
  logic       load, pd_keep, locked, banks, dll_on, wr_ready, hold, sync;
  logic       ton, wsel, clk_q, odt_q, ton_q, ws_q;
  logic [3:0] cl, cwl;
  logic [1:0] al, wrt;
  logic [2:0] nom;
  logic [4:0] lat;
  logic [7:0] le, he;
  int         rc, on_e, off_e, wr_e, ton_a, toff_a, ws_a, wsf_a;
  int         n_mismatch, checks_done;
  sdtc_link_if sdtc_link_if_inst ();
  wire lclk = sdtc_link_if_inst.dram_clk;
  wire lodt = sdtc_link_if_inst.odt;
  wire lwr  = sdtc_link_if_inst.wr_cmd;
  sdtc_ctrl_end sdtc_ctrl_end_inst (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .link(sdtc_link_if_inst), .term_req_in(term_req),
    .nominal_off_in(nom_off), .cke_in(cke), .wr_req_in(wr_req),
    .wr_bc4_in(wr_bc4), .wr_ready_out(wr_ready), .term_hold_out(hold));
  sdtc_dram_end sdtc_dram_end_inst (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .link(sdtc_link_if_inst), .mode_load_in(load),
    .cas_latency_in(cl), .cas_write_latency_in(cwl),
    .additive_field_in(al), .nominal_termination_in(nom),
    .write_termination_in(wrt), .dll_pd_keep_in(pd_keep),
    .dll_on_in(dll_on), .dll_locked_in(locked), .banks_open_in(banks),
    .sync_mode_out(sync), .term_on_out(ton), .term_write_sel_out(wsel),
    .term_latency_out(lat));
  sdtc_sva sdtc_sva_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .dram_clk(lclk), .cke(sdtc_link_if_inst.cke), .odt(lodt),
    .wr_cmd(lwr), .bc4(sdtc_link_if_inst.bc4));
  // 100 MHz reference clock
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // number link rises and note on which one each event lands; sampled
  // at the falling ref edge so every flop has settled
  always @(negedge ref_clk_in) begin
    if (lclk && !clk_q) begin
      rc++;
      if (lodt && !odt_q) on_e = rc;
      if (!lodt && odt_q) off_e = rc;
      if (lwr) wr_e = rc;
      odt_q = lodt;
    end
    if (ton && !ton_q) ton_a = rc;
    if (!ton && ton_q) toff_a = rc;
    if (wsel && !ws_q) ws_a = rc;
    if (!wsel && ws_q) wsf_a = rc;
    clk_q = lclk;
    ton_q = ton;
    ws_q = wsel;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %0d expected %0d", $time, got, exp);
    end
  endtask : chk
  task automatic clr();
    {on_e, off_e, wr_e, ton_a, toff_a, ws_a, wsf_a} = '0;
  endtask : clr
  task automatic set_mode(input logic [1:0] f, input logic [1:0] w);
    al = f;
    wrt = w;
    load = 1'b1;
    cyc(1);
    load = 1'b0;
    cyc(2);
  endtask : set_mode
  // request held until the pin rises; the controller keeps the hold
  task automatic pulse_term();
    int i;
    term_req = 1'b1;
    for (i = 0; i < 40 && lodt !== 1'b1; i++) cyc(1);
    term_req = 1'b0;
    if (i == 40) begin
      n_mismatch++;
      $display("ERROR %0t: termination pin never rose", $time);
      stop_test();
    end
    cyc(16);
    chk({7'h00, hold}, 8'h01);
    cyc(600);
    chk({7'h00, hold}, 8'h00);
  endtask : pulse_term
  task automatic write(input logic b);
    int i;
    wr_bc4 = b;
    wr_req = 1'b1;
    cyc(1);
    wr_req = 1'b0;
    term_req = 1'b0;
    for (i = 0; i < 40 && wr_ready !== 1'b1; i++) cyc(1);
    if (i == 40) begin
      n_mismatch++;
      $display("ERROR %0t: write never issued", $time);
      stop_test();
    end
    cyc(600);
  endtask : write
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  initial begin
    {term_req, nom_off, wr_req, wr_bc4, load, pd_keep} = '0;
    {clk_q, odt_q, ton_q, ws_q} = '0;
    {rst_in, cke, dll_on, locked, banks} = '1;
    {rc, n_mismatch, checks_done} = '0;
    cl = 4'h6;
    cwl = 4'h5;
    al = 2'h0;
    wrt = 2'h1;
    nom = 3'h1;
    cyc(5);
    rst_in = 1'b0;
    // every additive latency code with one short request
    for (int f = 0; f < 4; f++) begin
      le = (f == 1) ? 8'h08 : (f == 2) ? 8'h07 : 8'h03;
      set_mode(2'(f), 2'h1);
      chk({3'h0, lat}, le);
      clr();
      pulse_term();
      chk(8'(off_e - on_e), 8'h04);
      chk(8'(ton_a - on_e), le);
      chk(8'(toff_a - off_e), le);
      chk(8'(ws_a), 8'h00);
      $display("end of latency test %0d", f);
    end
    al = 2'h1;
    cyc(3);
    chk({3'h0, lat}, 8'h03);
    // writes inside a window: long, chopped, then dynamic off
    set_mode(2'h0, 2'h1);
    for (int b = 0; b < 3; b++) begin
      he = (b == 1) ? 8'h04 : 8'h06;
      if (b == 2) set_mode(2'h0, 2'h0);
      clr();
      term_req = 1'b1;
      cyc(40);
      write(b == 1);
      chk(8'(off_e - wr_e), he);
      chk(8'(ton_a - on_e), 8'h03);
      if (b < 2) begin
        chk(8'(ws_a - wr_e), 8'h03);
        chk(8'(wsf_a - wr_e), 8'h03 + he);
      end else
        chk(8'(ws_a), 8'h00);
      $display("end of write test %0d", b);
    end
    // sync mode needs a locked DLL, a termination value, a valid state
    set_mode(2'h0, 2'h1);
    chk({7'h00, sync}, 8'h01);
    locked = 1'b0;
    clr();
    pulse_term();
    chk({7'h00, sync}, 8'h00);
    chk(8'(ton_a), 8'h00);
    locked = 1'b1;
    nom = 3'h0;
    wrt = 2'h0;
    cyc(3);
    chk({7'h00, sync}, 8'h00);
    nom = 3'h1;
    banks = 1'b0;
    cke = 1'b0;
    cyc(40);
    chk({7'h00, sync}, 8'h00);
    pd_keep = 1'b1;
    cyc(3);
    chk({7'h00, sync}, 8'h01);
    pd_keep = 1'b0;
    banks = 1'b1;
    cyc(3);
    chk({7'h00, sync}, 8'h01);
    cke = 1'b1;
    $display("end of sync mode test");
    // pin parked high when only write termination matters
    nom = 3'h0;
    wrt = 2'h1;
    nom_off = 1'b1;
    cyc(600);
    chk({7'h00, lodt}, 8'h01);
    chk({7'h00, ton}, 8'h01);
    nom_off = 1'b0;
    cyc(200);
    chk({7'h00, lodt}, 8'h00);
    chk({7'h00, ton}, 8'h00);
    $display("end of parked pin test");
    stop_test();
  end
endmodule : tb_sync_dynamic_termination_ctrl
`default_nettype wire
